// ===== core/serial_pkg.sv
/*
 * Shared constants for the host serial command port: timing, character
 * codes, command opcodes, bit rate table, register map and state codes.
 * Assumes a single 50 MHz clock feeding every block that uses it.
 */
package serial_pkg;
	// Clock and timing
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned MS_CYC = CLK_HZ / 1000;
	localparam int unsigned GAP_MS = 200;
	localparam int unsigned GAP_CYC = MS_CYC * GAP_MS;
	localparam int unsigned PU_WAIT_MS = 2000;
	localparam int unsigned PU_WAIT_CYC = MS_CYC * PU_WAIT_MS;
	// Character framing
	localparam int unsigned DATA_BITS = 8;
	localparam logic [3:0] TX_SHIFTS = 4'h9;
	localparam logic [3:0] RX_START = 4'h9;
	// Character codes
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_ACK = 8'h25;
	localparam logic [7:0] CH_NAK = 8'h3f;
	localparam logic [7:0] CH_NUL = 8'h00;
	localparam logic [7:0] CH_PU = 8'hff;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_Z = 8'h5a;
	localparam logic [7:0] ERR_PARSE = 8'h31;
	localparam logic [7:0] ERR_TIMEOUT = 8'h32;
	localparam logic [7:0] ERR_FRAME = 8'h33;
	// Opcodes handled inside the port (two ASCII letters) and value limits
	localparam logic [15:0] OP_BIT_RATE = 16'h4252;
	localparam logic [15:0] OP_PU_BIT_RATE = 16'h5042;
	localparam logic [15:0] OP_RESP_DELAY = 16'h5444;
	localparam logic [15:0] OP_PROTOCOL = 16'h5052;
	localparam logic [15:0] DELAY_MAX = 16'h7fff;
	localparam logic [15:0] VAL_MAX = 16'hffff;
	// Bit rate codes
	localparam logic [2:0] RATE_9600 = 3'h1;
	localparam logic [2:0] RATE_MAX = 3'h5;
	// Register map and fields
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_DELAY = 8'h08;
	localparam logic [7:0] REG_LAST = 8'h0c;
	localparam int unsigned CTRL_ACK = 0;
	localparam int unsigned CTRL_ERR = 1;
	localparam logic [1:0] PROTO_RESET = 2'h0;

	// Divisor per bit rate code; unknown codes fall back to 9600
	function automatic logic [15:0] rate_div(input logic [2:0] code, input int unsigned clk_hz);
		case (code)
			3'h2: return 16'(clk_hz / 19200);
			3'h3: return 16'(clk_hz / 38400);
			3'h4: return 16'(clk_hz / 57600);
			3'h5: return 16'(clk_hz / 115200);
			default: return 16'(clk_hz / 9600);
		endcase
	endfunction

	typedef enum logic [2:0] {
		ST_PU_SEND = 3'b000,
		ST_PU_WAIT = 3'b001,
		ST_LISTEN = 3'b011,
		ST_DELAY = 3'b010,
		ST_REPLY = 3'b110
	} state_t;
endpackage

// ===== core/serial_uart.sv
/*
 * Character transmitter and receiver: 1 start, 8 data, no parity, 1 stop.
 * Assumes rxd is already synchronised to clk and div is stable per char.
 */
`timescale 1ns/1ps
module serial_tx (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Character in
	input wire logic [15:0] div,
	input wire logic go,
	input wire logic [7:0] data,
	output logic ready,
	// Line
	output logic txd,
	output logic txen
);
	logic [8:0] sh_q, sh_d;
	logic [3:0] n_q, n_d;
	logic [15:0] c_q, c_d;
	logic busy_q, busy_d;
	logic txd_q, txd_d;

	// Shift start, data LSB first, then stop; stop bit ends the frame
	always_comb begin
		sh_d = sh_q;
		n_d = n_q;
		c_d = c_q;
		busy_d = busy_q;
		txd_d = txd_q;
		if (!busy_q) begin
			if (go) begin
				busy_d = 1'b1;
				txd_d = 1'b0;
				sh_d = {1'b1, data};
				n_d = serial_pkg::TX_SHIFTS;
				c_d = div - 16'h0001;
			end
		end else if (c_q != 16'h0000) begin
			c_d = c_q - 16'h0001;
		end else if (n_q == 4'h0) begin
			busy_d = 1'b0;
		end else begin
			txd_d = sh_q[0];
			sh_d = {1'b1, sh_q[8:1]};
			n_d = n_q - 4'h1;
			c_d = div - 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sh_q <= 9'h1ff;
			n_q <= 4'h0;
			c_q <= 16'h0000;
			busy_q <= 1'b0;
			txd_q <= 1'b1;
		end else begin
			sh_q <= sh_d;
			n_q <= n_d;
			c_q <= c_d;
			busy_q <= busy_d;
			txd_q <= txd_d;
		end
	end

	assign ready = !busy_q;
	assign txd = txd_q;
	assign txen = busy_q;
endmodule

module serial_rx (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Line, synchronised
	input wire logic [15:0] div,
	input wire logic rxd,
	// Character out, one-cycle strobe
	output logic stb,
	output logic [7:0] data,
	output logic ferr
);
	logic [7:0] sh_q, sh_d;
	logic [3:0] n_q, n_d;
	logic [15:0] c_q, c_d;
	logic busy_q, busy_d, stb_q, stb_d, ferr_q, ferr_d;

	// Sample mid-bit; a start bit that is high again at mid-bit is noise
	always_comb begin
		sh_d = sh_q;
		n_d = n_q;
		c_d = c_q;
		busy_d = busy_q;
		stb_d = 1'b0;
		ferr_d = ferr_q;
		if (!busy_q) begin
			if (!rxd) begin
				busy_d = 1'b1;
				c_d = div >> 1;
				n_d = serial_pkg::RX_START;
			end
		end else if (c_q != 16'h0000) begin
			c_d = c_q - 16'h0001;
		end else begin
			c_d = div - 16'h0001;
			if (n_q == serial_pkg::RX_START) begin
				if (rxd)
					busy_d = 1'b0;
				else
					n_d = n_q - 4'h1;
			end else if (n_q != 4'h0) begin
				sh_d = {rxd, sh_q[7:1]};
				n_d = n_q - 4'h1;
			end else begin
				stb_d = 1'b1;
				ferr_d = !rxd;
				busy_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sh_q <= 8'h00;
			n_q <= 4'h0;
			c_q <= 16'h0000;
			busy_q <= 1'b0;
			stb_q <= 1'b0;
			ferr_q <= 1'b0;
		end else begin
			sh_q <= sh_d;
			n_q <= n_d;
			c_q <= c_d;
			busy_q <= busy_d;
			stb_q <= stb_d;
			ferr_q <= ferr_d;
		end
	end

	assign stb = stb_q;
	assign data = sh_q;
	assign ferr = ferr_q;
endmodule

// ===== core/host_serial_command_port.sv
/*
 * Host serial command port: power-up announcement, command packet parsing,
 * execution strobe and response packets, with an AHB-Lite register slave.
 * Assumes REF_CLK at 50 MHz, RXD from a pin, and an external executor
 * that consumes EXEC_STB for commands not handled here.
 */
`timescale 1ns/1ps
module host_serial_command_port #(
	parameter int unsigned GAP_CYC = serial_pkg::GAP_CYC,
	parameter int unsigned PU_WAIT_CYC = serial_pkg::PU_WAIT_CYC,
	parameter int unsigned MS_CYC = serial_pkg::MS_CYC,
	parameter int unsigned CLK_HZ = serial_pkg::CLK_HZ,
	parameter logic [7:0] FW_VERSION = 8'h11, // Arbitrary value
	parameter logic [7:0] MODEL_NO = 8'h22 // Arbitrary value
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Serial link
	input wire logic RXD,
	output logic TXD,
	output logic TXEN,
	// Command execution
	output logic EXEC_STB,
	output logic [15:0] EXEC_OP,
	output logic [15:0] EXEC_VAL,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP
);
	generate
		if (GAP_CYC < 1 || PU_WAIT_CYC < 1 || MS_CYC < 1 || MS_CYC > 65535 ||
				CLK_HZ / 115200 < 4 || CLK_HZ / 9600 > 65535)
			$error("host_serial_command_port: bad timing parameter");
	endgenerate

	serial_pkg::state_t st_q, st_d;
	logic rx_meta_q, rx_sync_q;
	logic [2:0] rate_q, rate_d, saved_q, saved_d;
	logic [1:0] proto_q, proto_d;
	logic [15:0] delay_q, delay_d, ms_left_q, ms_left_d, ms_pre_q, ms_pre_d;
	logic [31:0] timer_q, timer_d;
	logic forced_q, forced_d, pu_done_q, pu_done_d, zero_q, zero_d;
	logic pkt_q, pkt_d, bad_q, bad_d, ferr_q, ferr_d;
	logic [1:0] cnt_q, cnt_d, rep_len_q, rep_len_d, rep_idx_q, rep_idx_d;
	logic [15:0] op_q, op_d, val_q, val_d;
	logic [7:0] rep_q [0:2];
	logic [7:0] rep_d [0:2];
	logic exec_q, exec_d;
	logic [15:0] eop_q, eop_d, eval_q, eval_d;
	logic fin_good, fin_bad, tx_go;
	logic [7:0] tx_byte;
	logic [19:0] acc;
	logic [15:0] div;
	logic tx_ready, rx_stb, rx_ferr;
	logic [7:0] rx_byte;
	// Bus
	logic dp_wr_q, ready_q;
	logic [7:0] dp_addr_q;
	logic [31:0] rdata_q, rdata_d;
	logic addr_ok;

	// Divisor follows the live rate; it only changes between characters
	assign div = serial_pkg::rate_div(rate_q, CLK_HZ);

	// Pin synchroniser
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
		end else begin
			rx_meta_q <= RXD;
			rx_sync_q <= rx_meta_q;
		end
	end

	serial_rx u_rx (
		.clk(REF_CLK),
		.nrst(NRST),
		.div(div),
		.rxd(rx_sync_q),
		.stb(rx_stb),
		.data(rx_byte),
		.ferr(rx_ferr)
	);

	serial_tx u_tx (
		.clk(REF_CLK),
		.nrst(NRST),
		.div(div),
		.go(tx_go),
		.data(tx_byte),
		.ready(tx_ready),
		.txd(TXD),
		.txen(TXEN)
	);

	// Sequencer, parser and register writes
	always_comb begin
		st_d = st_q;
		rate_d = rate_q;
		saved_d = saved_q;
		proto_d = proto_q;
		delay_d = delay_q;
		ms_left_d = ms_left_q;
		ms_pre_d = ms_pre_q;
		timer_d = timer_q;
		forced_d = forced_q;
		pu_done_d = pu_done_q;
		zero_d = zero_q;
		pkt_d = pkt_q;
		bad_d = bad_q;
		ferr_d = ferr_q;
		cnt_d = cnt_q;
		op_d = op_q;
		val_d = val_q;
		rep_d = rep_q;
		rep_len_d = rep_len_q;
		rep_idx_d = rep_idx_q;
		exec_d = 1'b0;
		eop_d = eop_q;
		eval_d = eval_q;
		fin_good = 1'b0;
		fin_bad = 1'b0;
		tx_go = 1'b0;
		tx_byte = rep_q[rep_idx_q];
		acc = 20'(val_q) * 20'd10 + 20'(rx_byte - serial_pkg::CH_0);
		// Bus writes land first so a same-cycle command takes precedence
		if (dp_wr_q && dp_addr_q == serial_pkg::REG_CTRL)
			proto_d = HWDATA[1:0];
		if (dp_wr_q && dp_addr_q == serial_pkg::REG_DELAY)
			delay_d = (HWDATA[15:0] > serial_pkg::DELAY_MAX) ? serial_pkg::DELAY_MAX : HWDATA[15:0];
		unique case (st_q)
			serial_pkg::ST_PU_SEND, serial_pkg::ST_REPLY: begin
				// Next byte loads as soon as the previous stop bit ends
				if (rep_idx_q != rep_len_q) begin
					if (tx_ready) begin
						tx_go = 1'b1;
						rep_idx_d = rep_idx_q + 2'h1;
					end
				end else if (tx_ready) begin
					rep_idx_d = 2'h0;
					if (st_q == serial_pkg::ST_PU_SEND) begin
						st_d = serial_pkg::ST_PU_WAIT;
						timer_d = PU_WAIT_CYC;
					end else begin
						st_d = serial_pkg::ST_LISTEN;
					end
				end
			end
			serial_pkg::ST_PU_WAIT: begin
				// Two zero characters keep 9600; silence switches to the saved rate
				if (rx_stb && rx_byte == serial_pkg::CH_NUL) begin
					zero_d = 1'b1;
					if (zero_q) begin
						forced_d = 1'b1;
						pu_done_d = 1'b1;
						st_d = serial_pkg::ST_LISTEN;
					end
				end else if (rx_stb) begin
					zero_d = 1'b0;
				end else if (timer_q == 32'h0) begin
					rate_d = saved_q;
					pu_done_d = 1'b1;
					st_d = serial_pkg::ST_LISTEN;
				end else begin
					timer_d = timer_q - 32'h1;
				end
			end
			serial_pkg::ST_LISTEN: begin
				if (rx_stb) begin
					timer_d = GAP_CYC;
					if (rx_ferr)
						ferr_d = 1'b1;
					if (rx_byte == serial_pkg::CH_CR) begin
						if (pkt_q) begin
							fin_good = !bad_q && !rx_ferr && !ferr_q && cnt_q == 2'h2;
							fin_bad = !fin_good;
						end
					end else begin
						pkt_d = 1'b1;
						if (cnt_q != 2'h2) begin
							if (rx_byte >= serial_pkg::CH_A && rx_byte <= serial_pkg::CH_Z) begin
								op_d = {op_q[7:0], rx_byte};
								cnt_d = cnt_q + 2'h1;
							end else begin
								bad_d = 1'b1;
							end
						end else if (rx_byte >= serial_pkg::CH_0 && rx_byte <= serial_pkg::CH_9) begin
							val_d = (acc > 20'(serial_pkg::VAL_MAX)) ? serial_pkg::VAL_MAX : acc[15:0];
						end else begin
							bad_d = 1'b1;
						end
					end
				end else if (pkt_q) begin
					if (timer_q == 32'h0) begin
						pkt_d = 1'b0;
						cnt_d = 2'h0;
						bad_d = 1'b0;
						ferr_d = 1'b0;
						op_d = 16'h0000;
						val_d = 16'h0000;
						if (proto_q[serial_pkg::CTRL_ERR]) begin
							rep_d[0] = serial_pkg::CH_NAK;
							rep_d[1] = serial_pkg::ERR_TIMEOUT;
							rep_d[2] = serial_pkg::CH_CR;
							rep_len_d = 2'h3;
							st_d = serial_pkg::ST_DELAY;
							ms_left_d = delay_q;
							ms_pre_d = 16'h0000;
						end
					end else begin
						timer_d = timer_q - 32'h1;
					end
				end
				// Bit rate and delay commands are range checked before they count as understood; the protocol command is not
				if (fin_good) begin
					if (op_q == serial_pkg::OP_BIT_RATE || op_q == serial_pkg::OP_PU_BIT_RATE) begin
						if (val_q == 16'h0 || val_q > 16'(serial_pkg::RATE_MAX))
							fin_good = 1'b0;
						else
							saved_d = val_q[2:0];
					end else if (op_q == serial_pkg::OP_RESP_DELAY) begin
						if (val_q > serial_pkg::DELAY_MAX)
							fin_good = 1'b0;
						else
							delay_d = val_q;
					end else if (op_q == serial_pkg::OP_PROTOCOL) begin
						proto_d = val_q[1:0];
					end
					fin_bad = !fin_good;
				end
				if (fin_good) begin
					exec_d = 1'b1;
					eop_d = op_q;
					eval_d = val_q;
				end
				if (fin_good || fin_bad) begin
					pkt_d = 1'b0;
					cnt_d = 2'h0;
					bad_d = 1'b0;
					ferr_d = 1'b0;
					op_d = 16'h0000;
					val_d = 16'h0000;
					rep_len_d = 2'h0;
					if (fin_good && proto_q[serial_pkg::CTRL_ACK]) begin
						rep_d[0] = serial_pkg::CH_ACK;
						rep_d[1] = serial_pkg::CH_CR;
						rep_len_d = 2'h2;
					end else if (fin_bad && proto_q[serial_pkg::CTRL_ERR]) begin
						rep_d[0] = serial_pkg::CH_NAK;
						rep_d[1] = (ferr_q || rx_ferr) ? serial_pkg::ERR_FRAME : serial_pkg::ERR_PARSE;
						rep_d[2] = serial_pkg::CH_CR;
						rep_len_d = 2'h3;
					end else if (fin_bad && proto_q[serial_pkg::CTRL_ACK]) begin
						rep_d[0] = serial_pkg::CH_NAK;
						rep_d[1] = serial_pkg::CH_CR;
						rep_len_d = 2'h2;
					end
					if (rep_len_d != 2'h0) begin
						st_d = serial_pkg::ST_DELAY;
						ms_left_d = delay_q;
						ms_pre_d = 16'h0000;
					end
				end
			end
			serial_pkg::ST_DELAY: begin
				// Millisecond prescaler keeps the delay counter narrow
				if (ms_left_q == 16'h0000) begin
					st_d = serial_pkg::ST_REPLY;
				end else if (ms_pre_q == 16'(MS_CYC - 1)) begin
					ms_pre_d = 16'h0000;
					ms_left_d = ms_left_q - 16'h0001;
				end else begin
					ms_pre_d = ms_pre_q + 16'h0001;
				end
			end
			default: st_d = serial_pkg::ST_LISTEN;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			st_q <= serial_pkg::ST_PU_SEND;
			rate_q <= serial_pkg::RATE_9600;
			saved_q <= serial_pkg::RATE_9600;
			proto_q <= serial_pkg::PROTO_RESET;
			delay_q <= 16'h0000;
			ms_left_q <= 16'h0000;
			ms_pre_q <= 16'h0000;
			timer_q <= 32'h0;
			forced_q <= 1'b0;
			pu_done_q <= 1'b0;
			zero_q <= 1'b0;
			pkt_q <= 1'b0;
			bad_q <= 1'b0;
			ferr_q <= 1'b0;
			cnt_q <= 2'h0;
			op_q <= 16'h0000;
			val_q <= 16'h0000;
			rep_q[0] <= serial_pkg::CH_PU;
			rep_q[1] <= FW_VERSION;
			rep_q[2] <= MODEL_NO;
			rep_len_q <= 2'h3;
			rep_idx_q <= 2'h0;
			exec_q <= 1'b0;
			eop_q <= 16'h0000;
			eval_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			rate_q <= rate_d;
			saved_q <= saved_d;
			proto_q <= proto_d;
			delay_q <= delay_d;
			ms_left_q <= ms_left_d;
			ms_pre_q <= ms_pre_d;
			timer_q <= timer_d;
			forced_q <= forced_d;
			pu_done_q <= pu_done_d;
			zero_q <= zero_d;
			pkt_q <= pkt_d;
			bad_q <= bad_d;
			ferr_q <= ferr_d;
			cnt_q <= cnt_d;
			op_q <= op_d;
			val_q <= val_d;
			rep_q <= rep_d;
			rep_len_q <= rep_len_d;
			rep_idx_q <= rep_idx_d;
			exec_q <= exec_d;
			eop_q <= eop_d;
			eval_q <= eval_d;
		end
	end

	assign EXEC_STB = exec_q;
	assign EXEC_OP = eop_q;
	assign EXEC_VAL = eval_q;

	// Zero-wait slave: read data is chosen in the address phase
	assign addr_ok = HSEL && HTRANS[1] && HREADY;
	always_comb begin
		rdata_d = 32'h0;
		if (addr_ok && !HWRITE) begin
			unique case (HADDR[7:0])
				serial_pkg::REG_CTRL: rdata_d = {30'h0, proto_q};
				serial_pkg::REG_STAT: rdata_d = {21'h0, saved_q, 1'b0, rate_q, 1'b0, pkt_q, forced_q, pu_done_q};
				serial_pkg::REG_DELAY: rdata_d = {16'h0, delay_q};
				serial_pkg::REG_LAST: rdata_d = {eop_q, eval_q};
				default: rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			dp_wr_q <= 1'b0;
			dp_addr_q <= 8'h00;
			rdata_q <= 32'h0;
			ready_q <= 1'b0;
		end else begin
			dp_wr_q <= addr_ok && HWRITE;
			dp_addr_q <= HADDR[7:0];
			rdata_q <= rdata_d;
			ready_q <= 1'b1;
		end
	end

	assign HRDATA = rdata_q;
	assign HREADYOUT = ready_q;
	assign HRESP = 1'b0; // Always OKAY

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!NRST);

	AST_PU_RATE: assert property (st_q inside {serial_pkg::ST_PU_SEND, serial_pkg::ST_PU_WAIT} |-> rate_q == serial_pkg::RATE_9600)
		else $error("rate left 9600 during power-up");
	AST_QUIET: assert property (st_q == serial_pkg::ST_LISTEN && !$past(tx_go) |-> TXEN == 1'b0)
		else $error("transmitter busy while listening");
	AST_RELOAD: assert property (st_q == serial_pkg::ST_LISTEN && rx_stb |=> timer_q == GAP_CYC)
		else $error("gap timer not reloaded");
	AST_ABANDON: assert property (st_q == serial_pkg::ST_LISTEN && pkt_q && !rx_stb && timer_q == 32'h0 |=> !pkt_q && cnt_q == 2'h0)
		else $error("packet not abandoned on timeout");
	AST_B2B: assert property (st_q == serial_pkg::ST_REPLY && tx_ready && rep_idx_q != rep_len_q |-> tx_go ##1 !tx_ready)
		else $error("gap between response characters");
	AST_CR_END: assert property (tx_go && st_q == serial_pkg::ST_REPLY && rep_idx_q == rep_len_q - 2'h1 |-> tx_byte == serial_pkg::CH_CR)
		else $error("response not ended by carriage return");
	AST_NO_BAD_EXEC: assert property (fin_bad |=> !EXEC_STB)
		else $error("uninterpretable command executed");
	AST_ACK: assert property (fin_good && proto_q[serial_pkg::CTRL_ACK] |=> rep_q[0] == serial_pkg::CH_ACK && rep_len_q == 2'h2 ##1 st_q inside {serial_pkg::ST_DELAY, serial_pkg::ST_REPLY})
		else $error("acknowledge not queued");
	AST_DELAY: assert property (st_q == serial_pkg::ST_DELAY && ms_left_q != 16'h0000 |=> st_q == serial_pkg::ST_DELAY)
		else $error("response delay cut short");
	AST_NO_OVERLAP: assert property (st_q inside {serial_pkg::ST_DELAY, serial_pkg::ST_REPLY} |-> !pkt_q)
		else $error("reply while command arriving");

	CV_FORCED: cover property ($rose(forced_q));
	CV_EXEC: cover property (EXEC_STB && proto_q[serial_pkg::CTRL_ACK]);
	CV_TIMEOUT: cover property (st_q == serial_pkg::ST_LISTEN && pkt_q && timer_q == 32'h0 && !rx_stb);
	CV_RATE: cover property (pu_done_q && rate_q != serial_pkg::RATE_9600);
endmodule

// ===== dv/host_serial_model.sv
/*
 * Behavioural host for the serial command port: sends 8N1 characters at
 * 9600 baud and collects every character the port transmits.
 * Assumes one clock shared with the port, 20 ns period, idle-high lines.
 */
`timescale 1ns/1ps
module host_serial_model #(
	parameter int BIT = serial_pkg::CLK_HZ / 9600
) (
	// Clock
	input wire logic clk,
	// Line
	input wire logic txd,
	output logic rxd
);
	longint cyc = 0;
	longint sent_end = 0;
	logic sending = 1'b0;
	logic [7:0] rx_q[$];
	longint rx_t[$];

	// Cycle count used to time the port's characters
	always @(posedge clk) begin
		cyc <= cyc + 1;
	end

	initial begin
		rxd = 1'b1;
	end

	// Start bit, data LSB first, stop bit; characters follow back to back
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		sending = 1'b1;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			rxd <= f[i];
			repeat (BIT - 1) @(posedge clk);
		end
		sending = 1'b0;
		sent_end = cyc;
	endtask

	// Mid-bit sampling; a bad stop bit drops the character so it shows missing
	initial begin
		logic [7:0] b;
		longint t;
		forever begin
			@(negedge txd);
			t = cyc;
			repeat (BIT / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clk);
				b[i] = txd;
			end
			repeat (BIT) @(posedge clk);
			if (txd === 1'b1) begin
				rx_q.push_back(b);
				rx_t.push_back(t);
			end
		end
	end
endmodule

// ===== dv/test_host_serial_command_port.sv
/*
 * Self-checking bench for the host serial command port: power-up packet,
 * double zero, registers, good, bad and timed-out command packets.
 * Assumes host_serial_model.sv and short timing parameters.
 */
`timescale 1ns/1ps
module test_host_serial_command_port;
	// Scaled rate keeps a character near 1000 cycles so the run stays short
	localparam int unsigned SIM_HZ = 960000;
	localparam int unsigned GAP = 3000;
	localparam int unsigned MSC = 20;
	localparam int BIT = SIM_HZ / 9600;
	logic REF_CLK, NRST, RXD, TXD, TXEN, EXEC_STB, HSEL, HWRITE, HREADYOUT, HRESP;
	logic [15:0] EXEC_OP, EXEC_VAL;
	logic [31:0] HADDR, HWDATA, HRDATA, rd;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	int errors = 0;
	int checked = 0;
	int stb_n = 0;
	int clash = 0;
	int s0;
	longint first_t;

	host_serial_command_port #(.CLK_HZ(SIM_HZ), .GAP_CYC(GAP), .PU_WAIT_CYC(6000),
			.MS_CYC(MSC)) DUT (
		.REF_CLK(REF_CLK), .NRST(NRST), .RXD(RXD), .TXD(TXD), .TXEN(TXEN),
		.EXEC_STB(EXEC_STB), .EXEC_OP(EXEC_OP), .EXEC_VAL(EXEC_VAL),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP));
	host_serial_model #(.BIT(BIT)) HOST (.clk(REF_CLK), .txd(TXD), .rxd(RXD));

	initial begin
		REF_CLK = 1'b0;
		forever #10 REF_CLK = ~REF_CLK;
	end

	// Strobe count, and any port drive while the host is still sending
	always @(posedge REF_CLK) begin
		if (EXEC_STB === 1'b1)
			stb_n <= stb_n + 1;
		if (TXEN === 1'b1 && HOST.sending)
			clash <= clash + 1;
	end

	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Edge at which the slave shows ready; a hang ends the run
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			tally_and_finish;
		end
	endtask

	// One single word transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {24'h0, a};
		HWRITE <= wr;
		wait_ready();
		HTRANS <= 2'h0;
		HWDATA <= d;
		wait_ready();
		rd = HRDATA;
	endtask

	task automatic send_str(input string s);
		foreach (s[i]) HOST.send_byte(s[i]);
	endtask

	// Waits for the whole reply, checks characters and spacing, then lets the
	// last stop bit end so the host never talks over the port's driver
	task automatic expect_reply(input string s);
		int n;
		n = 0;
		while (HOST.rx_q.size() < s.len() && n < 20000) begin
			@(posedge REF_CLK);
			n++;
		end
		if (n >= 20000) begin
			errors++;
			tally_and_finish;
		end
		first_t = HOST.rx_t[0];
		for (int i = 0; i < s.len(); i++) begin
			chk("reply char", {24'h0, s[i]}, {24'h0, HOST.rx_q[i]});
			if (i > 0)
				chk("char spacing", 1, HOST.rx_t[i] - HOST.rx_t[i-1] < 11 * BIT);
		end
		HOST.rx_q.delete();
		HOST.rx_t.delete();
		repeat (BIT) @(posedge REF_CLK);
	endtask

	task automatic t_power_up;
		int n;
		expect_reply("\377\021\042");
		repeat (BIT) @(posedge REF_CLK);
		HOST.send_byte(8'h00);
		HOST.send_byte(8'h00);
		n = 0;
		do begin
			repeat (200) @(posedge REF_CLK);
			bus(1'b0, serial_pkg::REG_STAT, 32'h0);
			n++;
		end while (rd[0] !== 1'b1 && n < 80);
		chk("power-up done", 1, rd[0]);
		chk("forced flag", 1, rd[1]);
		chk("live rate", serial_pkg::RATE_9600, rd[6:4]);
		chk("saved rate", serial_pkg::RATE_9600, rd[10:8]);
		$display("test power_up done");
	endtask

	task automatic t_regs;
		bus(1'b0, serial_pkg::REG_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		bus(1'b1, serial_pkg::REG_CTRL, 32'h3);
		bus(1'b0, serial_pkg::REG_CTRL, 32'h0);
		chk("ctrl", 32'h3, rd);
		bus(1'b1, serial_pkg::REG_DELAY, 32'hffff);
		bus(1'b0, serial_pkg::REG_DELAY, 32'h0);
		chk("delay clip", 32'h7fff, rd);
		bus(1'b1, serial_pkg::REG_DELAY, 32'd300);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("hresp", 0, HRESP);
		$display("test regs done");
	endtask

	// Good command: strobe, ack, delayed start; then a bad one
	task automatic t_commands;
		s0 = stb_n;
		send_str("AC5\015");
		expect_reply("%\015");
		chk("delay low", 1, first_t - HOST.sent_end > 300 * MSC - BIT);
		chk("delay high", 1, first_t - HOST.sent_end < 300 * MSC + BIT);
		chk("strobes", 1, stb_n - s0);
		chk("op", 32'h4143, EXEC_OP);
		chk("val", 32'h5, EXEC_VAL);
		bus(1'b0, serial_pkg::REG_LAST, 32'h0);
		chk("last", 32'h41430005, rd);
		s0 = stb_n;
		send_str("a1\015");
		expect_reply("?1\015");
		chk("bad strobes", 0, stb_n - s0);
		send_str("BR3\015");
		expect_reply("%\015");
		bus(1'b0, serial_pkg::REG_STAT, 32'h0);
		chk("saved after command", 32'h3, rd[10:8]);
		chk("live after command", serial_pkg::RATE_9600, rd[6:4]);
		$display("test commands done");
	endtask

	task automatic t_timeout;
		s0 = stb_n;
		send_str("A");
		expect_reply("?2\015");
		chk("gap low", 1, first_t - HOST.sent_end >= GAP);
		chk("gap high", 1, first_t - HOST.sent_end < GAP + 300 * MSC);
		chk("timeout strobes", 0, stb_n - s0);
		$display("test timeout done");
	endtask

	// Ack without codes, then no reply at all
	task automatic t_quiet;
		bus(1'b1, serial_pkg::REG_CTRL, 32'h1);
		send_str("a\015");
		expect_reply("?\015");
		bus(1'b1, serial_pkg::REG_CTRL, 32'h0);
		s0 = stb_n;
		send_str("AC7\015");
		repeat (10000) @(posedge REF_CLK);
		chk("silent", 0, HOST.rx_q.size());
		chk("quiet strobes", 1, stb_n - s0);
		chk("drive while host sends", 0, clash);
		$display("test quiet done");
	endtask

	initial begin
		NRST = 1'b0;
		HSEL = 1'b0;
		HTRANS = 2'h0;
		HADDR = 32'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h0;
		repeat (3) @(posedge REF_CLK);
		chk("txd in reset", 1, TXD);
		chk("txen in reset", 0, TXEN);
		NRST <= 1'b1;
		t_power_up();
		t_regs();
		t_commands();
		t_timeout();
		t_quiet();
		tally_and_finish();
	end
endmodule
